// [logic/csi_defines.vh]
// Constants and behaviour summary for the clocked serial interface
// Behaviour
// - Eight-bit shift register, four-bit mode register, three-bit bit counter.
// - Low mode bits 000 stop serial operation; all three pins are port inputs.
// - Mode 010 drives system clock, 011 drives timer-out on clock pin; no shifting.
// - Mode 100 shifts with external clock input; data in and data out active.
// - Mode 110 shifts on system clock, 111 on timer-out, clock driven out.
// - Mode bit 3 selects transfer interrupt (0) or external pin interrupt (1).
// - Input sampled on serial clock rise; output changes after serial clock fall.
`ifndef CSI_DEFINES_VH
`define CSI_DEFINES_VH

// Register byte offsets
`define CSI_OFS_MODE      4'h0
`define CSI_OFS_DATA      4'h4
`define CSI_OFS_STATUS    4'h8
`define CSI_OFS_MASK      4'hc
`define CSI_OFS_PORT      4'h0
`define CSI_ADDR_W        5
`define CSI_OFS_PORTREG   5'h10

// Reset values
`define CSI_MODE_RST      4'h0
`define CSI_DATA_RST      8'h00
`define CSI_MASK_RST      2'h0

// Mode field
`define CSI_MODE_SEL_BIT  3
`define CSI_MODE_STOP     3'h0
`define CSI_MODE_PHI_OUT  3'h2
`define CSI_MODE_TMR_OUT  3'h3
`define CSI_MODE_EXT      3'h4
`define CSI_MODE_PHI      3'h6
`define CSI_MODE_TMR      3'h7

// Status and mask bit positions
`define CSI_ST_XFER       0
`define CSI_ST_EXT        1

// Port register bit positions
`define CSI_PT_SCK        0
`define CSI_PT_SO         1
`define CSI_PT_SI         2
`define CSI_PT_BUSY       3

// Half period of the internal system clock, in clk cycles
`define CSI_PHI_HALF      4'h4

// Bus responses
`define CSI_RESP_OKAY     2'h0
`define CSI_RESP_SLVERR   2'h2

`endif

// [logic/csi_serial.v]
// Clocked serial interface with AXI4-Lite register access
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`include "csi_defines.vh"

module csi_serial (
	input  wire        clk,
	input  wire        reset,
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        si_i,
	input  wire        so_i,
	output wire        so_o,
	output wire        so_oe,
	input  wire        sck_i,
	output wire        sck_o,
	output wire        sck_oe,
	input  wire        ext_int_i,
	input  wire        timer_out_signal,
	output wire        irq
);

	// Register file
	reg  [3:0]  mode_r;
	reg  [7:0]  shreg_r;
	reg  [2:0]  bitcnt_r;
	reg         busy_r;
	reg  [1:0]  status_r;
	reg  [1:0]  mask_r;

	// Bus slave state
	reg         awready_r;
	reg         wready_r;
	reg         bvalid_r;
	reg  [1:0]  bresp_r;
	reg  [4:0]  awaddr_r;
	reg  [31:0] wdata_r;
	reg  [3:0]  wstrb_r;
	reg         arready_r;
	reg         rvalid_r;
	reg  [31:0] rdata_r;
	reg  [1:0]  rresp_r;

	// Pin side
	reg  [2:0]  sck_sy_r;
	reg  [2:0]  si_sy_r;
	reg  [2:0]  so_sy_r;
	reg  [2:0]  int_sy_r;
	reg         sck_f_r;
	reg         si_f_r;
	reg         so_f_r;
	reg         int_f_r;
	reg         src_prev_r;
	reg  [3:0]  phi_cnt_r;
	reg         phi_r;
	reg         so_o_r;
	reg         so_oe_r;
	reg         sck_o_r;
	reg         sck_oe_r;
	reg         irq_r;

	wire [2:0]  mode_lo   = mode_r[2:0];
	wire        sel_ext   = mode_r[`CSI_MODE_SEL_BIT];
	wire        shift_md  = (mode_lo == `CSI_MODE_EXT) || (mode_lo == `CSI_MODE_PHI) ||
				(mode_lo == `CSI_MODE_TMR);
	wire        int_clk   = (mode_lo == `CSI_MODE_PHI) || (mode_lo == `CSI_MODE_TMR);

	// Shift clock source per mode
	reg         src;
	always @* begin
		case (mode_lo)
			`CSI_MODE_EXT: src = sck_f_r;
			`CSI_MODE_PHI: src = phi_r;
			`CSI_MODE_TMR: src = timer_out_signal;
			default:       src = 1'b1;
		endcase
	end

	wire        src_rise  = src & ~src_prev_r;
	wire        src_fall  = ~src & src_prev_r;
	wire        do_rise   = busy_r & shift_md & src_rise;
	wire        xfer_done = do_rise & (bitcnt_r == 3'h7);
	wire        ext_evt   = int_f_r == 1'b0 && int_sy_r[2] == 1'b1 && int_sy_r[1] == 1'b1;

	wire        aw_hs     = s_axi_awvalid & awready_r;
	wire        w_hs      = s_axi_wvalid & wready_r;
	wire        wr_go     = ~awready_r & ~wready_r & ~bvalid_r;
	wire        ar_hs     = s_axi_arvalid & arready_r;
	wire        wr_low    = wstrb_r[0];
	wire        wr_mode   = wr_go & wr_low & (awaddr_r == {1'b0, `CSI_OFS_MODE});
	wire        wr_data   = wr_go & wr_low & (awaddr_r == {1'b0, `CSI_OFS_DATA});
	wire        wr_mask   = wr_go & wr_low & (awaddr_r == {1'b0, `CSI_OFS_MASK});
	wire        wr_hit    = (awaddr_r == {1'b0, `CSI_OFS_MODE}) ||
				(awaddr_r == {1'b0, `CSI_OFS_DATA}) ||
				(awaddr_r == {1'b0, `CSI_OFS_STATUS}) ||
				(awaddr_r == {1'b0, `CSI_OFS_MASK}) ||
				(awaddr_r == `CSI_OFS_PORTREG);
	// Decoded on the aligned word, as the read mux does, so every alias of STATUS clears
	wire        rd_stat   = ar_hs & ({s_axi_araddr[4:2], 2'b00} == {1'b0, `CSI_OFS_STATUS});

	// Three-stage synchronisers; a new level counts once stages two and three agree
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sck_sy_r <= 3'h7;
			si_sy_r  <= 3'h0;
			so_sy_r  <= 3'h0;
			int_sy_r <= 3'h0;
			sck_f_r  <= 1'b1;
			si_f_r   <= 1'b0;
			so_f_r   <= 1'b0;
			int_f_r  <= 1'b0;
		end else begin
			sck_sy_r <= {sck_sy_r[1:0], sck_i};
			si_sy_r  <= {si_sy_r[1:0], si_i};
			so_sy_r  <= {so_sy_r[1:0], so_i};
			int_sy_r <= {int_sy_r[1:0], ext_int_i};
			if (sck_sy_r[1] == sck_sy_r[2]) begin
				sck_f_r <= sck_sy_r[2];
			end
			if (si_sy_r[1] == si_sy_r[2]) begin
				si_f_r <= si_sy_r[2];
			end
			if (so_sy_r[1] == so_sy_r[2]) begin
				so_f_r <= so_sy_r[2];
			end
			if (int_sy_r[1] == int_sy_r[2]) begin
				int_f_r <= int_sy_r[2];
			end
		end
	end

	// Internal system clock, a free running divider of clk
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			phi_cnt_r <= 4'h0;
			phi_r     <= 1'b1;
		end else if (phi_cnt_r == `CSI_PHI_HALF - 4'h1) begin
			phi_cnt_r <= 4'h0;
			phi_r     <= ~phi_r;
		end else begin
			phi_cnt_r <= phi_cnt_r + 4'h1;
		end
	end

	// Shift engine
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			shreg_r    <= `CSI_DATA_RST;
			bitcnt_r   <= 3'h0;
			busy_r     <= 1'b0;
			src_prev_r <= 1'b1;
			so_o_r     <= 1'b0;
		end else begin
			src_prev_r <= src;
			if (!shift_md) begin
				busy_r <= 1'b0;
			end else if (wr_data && !busy_r) begin
				shreg_r  <= wdata_r[7:0];
				bitcnt_r <= 3'h0;
				busy_r   <= 1'b1;
			end else if (do_rise) begin
				shreg_r  <= {shreg_r[6:0], si_f_r};
				bitcnt_r <= bitcnt_r + 3'h1;
				if (xfer_done) begin
					busy_r <= 1'b0;
				end
			end
			if (busy_r && shift_md && src_fall) begin
				so_o_r <= shreg_r[7];
			end
		end
	end

	// Pin drivers; output enable high while the pin is driven
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			so_oe_r  <= 1'b0;
			sck_oe_r <= 1'b0;
			sck_o_r  <= 1'b1;
		end else begin
			so_oe_r <= shift_md;
			case (mode_lo)
				`CSI_MODE_PHI_OUT: begin
					sck_oe_r <= 1'b1;
					sck_o_r  <= phi_r;
				end
				`CSI_MODE_TMR_OUT: begin
					sck_oe_r <= 1'b1;
					sck_o_r  <= timer_out_signal;
				end
				`CSI_MODE_PHI, `CSI_MODE_TMR: begin
					sck_oe_r <= 1'b1;
					// Idle high so the partner sees no stray edges between bytes
					sck_o_r  <= busy_r ? src : 1'b1;
				end
				default: begin
					sck_oe_r <= 1'b0;
					sck_o_r  <= 1'b1;
				end
			endcase
		end
	end

	// Sticky status, mask and interrupt request
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			status_r <= 2'h0;
			mask_r   <= `CSI_MASK_RST;
			mode_r   <= `CSI_MODE_RST;
			irq_r    <= 1'b0;
		end else begin
			// A set in the same cycle as the read wins over the clear
			status_r <= (rd_stat ? 2'h0 : status_r) | {ext_evt, xfer_done};
			if (wr_mask) begin
				mask_r <= wdata_r[1:0];
			end
			if (wr_mode) begin
				mode_r <= wdata_r[3:0];
			end
			if (sel_ext) begin
				irq_r <= status_r[`CSI_ST_EXT] & mask_r[`CSI_ST_EXT];
			end else begin
				irq_r <= status_r[`CSI_ST_XFER] & mask_r[`CSI_ST_XFER];
			end
		end
	end

	// Write channel: address and data taken in either order, then one response
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= `CSI_RESP_OKAY;
			awaddr_r  <= 5'h00;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
		end else begin
			if (aw_hs) begin
				awready_r <= 1'b0;
				awaddr_r  <= {s_axi_awaddr[4:2], 2'b00};
			end
			if (w_hs) begin
				wready_r <= 1'b0;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_hit ? `CSI_RESP_OKAY : `CSI_RESP_SLVERR;
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Read channel: data one cycle after the address is taken
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `CSI_RESP_OKAY;
		end else begin
			if (ar_hs) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rresp_r   <= `CSI_RESP_OKAY;
				case ({s_axi_araddr[4:2], 2'b00})
					{1'b0, `CSI_OFS_MODE}:   rdata_r <= {28'h0, mode_r};
					{1'b0, `CSI_OFS_DATA}:   rdata_r <= {24'h0, shreg_r};
					{1'b0, `CSI_OFS_STATUS}: rdata_r <= {30'h0, status_r};
					{1'b0, `CSI_OFS_MASK}:   rdata_r <= {30'h0, mask_r};
					`CSI_OFS_PORTREG: begin
						// Pin levels read as port inputs in stop mode
						rdata_r <= {28'h0, busy_r, si_f_r, so_f_r, sck_f_r};
					end
					default: begin
						rdata_r <= 32'h00000000;
						rresp_r <= `CSI_RESP_SLVERR;
					end
				endcase
			end
			if (rvalid_r && s_axi_rready) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign so_o          = so_o_r;
	assign so_oe         = so_oe_r;
	assign sck_o         = sck_o_r;
	assign sck_oe        = sck_oe_r;
	assign irq           = irq_r;

endmodule // csi_serial

// [tb/csi_partner.sv]
// Behavioural far-side peripheral that clocks one byte per frame
module csi_partner (
	input  wire        start,
	input  wire [7:0]  tx,
	input  wire        so,
	output logic       sck,
	output logic       si,
	output logic [7:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sck = 1'b1;
		si = 1'b0;
		rx = 8'h00;
	end
	// Clock stands high between frames; 125 ns period inside a frame
	always @(posedge start) begin
		for (int i = 7; i >= 0; i--) begin
			#20 sck = 1'b0;
			si = tx[i];
			#62.5 sck = 1'b1;
			rx = {rx[6:0], so};
			#42.5;
		end
		// Hold time over, so the line no longer shows the last bit
		si = ~si;
	end
endmodule // csi_partner

// [tb/csi_serial_checker.sv]
// Assertions on pin drive and interrupt timing of the serial block
module csi_serial_checker (
	input wire        clk,
	input wire        reset,
	input wire [4:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0]  s_axi_wstrb,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        so_o,
	input wire        so_oe,
	input wire        sck_i,
	input wire        sck_oe,
	input wire        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [3:0] m_r;
	logic [1:0] k_r;
	wire        wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// Shadow copies run ahead of the block, so mode checks wait a few cycles
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			m_r <= 4'h0;
			k_r <= 2'h0;
		end else if (wr_go && s_axi_wstrb[0]) begin
			if (s_axi_awaddr == 5'h00) m_r <= s_axi_wdata[3:0];
			if (s_axi_awaddr == 5'h0c) k_r <= s_axi_wdata[1:0];
		end
	end
	sequence s_mode(logic [2:0] v);
		(m_r[2:0] == v)[*4];
	endsequence
	a_stop_no_drive: assert property (s_mode(3'h0) |-> !so_oe && !sck_oe)
		else $error("pins driven in stop mode");
	a_clock_out_drive: assert property (s_mode(3'h2) or s_mode(3'h3) |-> sck_oe && !so_oe)
		else $error("clock pin not driven in clock output mode");
	a_ext_clock_in: assert property (s_mode(3'h4) |-> !sck_oe && so_oe)
		else $error("wrong pin drive with external clock");
	a_own_clock_out: assert property (s_mode(3'h6) or s_mode(3'h7) |-> sck_oe && so_oe)
		else $error("clock pin not driven with own clock");
	a_irq_source_mask: assert property ($rose(irq) |-> k_r[m_r[3]])
		else $error("interrupt from deselected or masked source");
	a_out_after_fall: assert property ((m_r[2:0] == 3'h4)[*8] ##0 $changed(so_o) |-> !sck_i)
		else $error("data out changed while clock high");
	a_done_after_rise: assert property ($rose(irq) && m_r == 4'h4 |-> sck_i)
		else $error("transfer done not after a rising clock");
	// The response is registered one cycle after both halves are held
	a_write_answer: assert property (wr_go |=> ##1 s_axi_bvalid)
		else $error("write response late");
endmodule // csi_serial_checker
bind csi_serial csi_serial_checker chk (.*);

// [tb/csi_serial_bench.sv]
// Self-checking bench for the clocked serial interface
module csi_serial_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, reset = 1'b1, start = 1'b0, tmr_en = 1'b0;
	logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, ext_int_i = 0, timer_out_signal = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        so_o, so_oe, sck_o, sck_oe, irq, psck, si_i;
	logic [1:0]  s_axi_bresp, s_axi_rresp, br;
	logic [7:0]  prx;
	int          errors = 0, checks_done = 0, n;
	wire         sck_i = sck_oe ? sck_o : psck;
	wire         so_i = so_oe ? so_o : 1'b0;
	csi_serial dut (.*);
	csi_partner peer (.start(start), .tx(8'h3c), .so(so_i), .sck(psck), .si(si_i), .rx(prx));
	initial forever #4 clk = ~clk;
	always begin
		repeat (4) @(posedge clk);
		if (tmr_en) timer_out_signal <= ~timer_out_signal;
	end
	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// One idle edge so the next call never reassigns ready in this time step
		@(posedge clk);
	endtask
	task automatic rd(input logic [4:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	task automatic wirq;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("irq raised", 1, irq);
	endtask
	task automatic hi8;
		n = 0;
		repeat (8) begin
			@(posedge clk);
			n += sck_o;
		end
	endtask
	task give_verdict;
		if (errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Whole run needs well under 5000 cycles
	initial begin
		#100000;
		errors++;
		give_verdict;
	end
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(5'h00);
		chk("mode reset", 0, d);
		chk("pin drive", 0, {so_oe, sck_oe});
		rd(5'h10);
		chk("port pins", 1, d);
		rd(5'h14);
		chk("unmapped resp", 2, s_axi_rresp);
		wr(5'h14, 32'h00000001);
		chk("unmapped wr resp", 2, br);
		wr(5'h00, 2);
		chk("mode wr resp", 0, br);
		repeat (4) @(posedge clk);
		hi8;
		chk("clock out highs", 4, n);
		wr(5'h00, 3);
		repeat (4) @(posedge clk);
		chk("timer clock drive", 1, sck_oe);
		// Timer held low first, so a copy of the system clock would show here
		hi8;
		chk("timer held low", 0, n);
		tmr_en <= 1'b1;
		repeat (8) @(posedge clk);
		hi8;
		chk("timer clock highs", 4, n);
		wr(5'h0c, 1);
		wr(5'h00, 4);
		wr(5'h04, 8'ha5);
		start <= 1'b1;
		wirq;
		start <= 1'b0;
		chk("peer byte", 8'ha5, prx);
		rd(5'h04);
		chk("received byte", 8'h3c, d);
		rd(5'h08);
		chk("done status", 1, d);
		repeat (3) @(posedge clk);
		chk("irq cleared", 0, irq);
		for (int m = 6; m < 8; m++) begin
			wr(5'h00, m);
			wr(5'h04, 8'h81);
			wirq;
			chk("own clock drive", 1, sck_oe);
			rd(5'h04);
			chk("own clock byte", 8'hff, d);
			rd(5'h08);
			chk("own clock status", 1, d);
		end
		wr(5'h00, 8);
		ext_int_i <= 1'b1;
		repeat (8) @(posedge clk);
		ext_int_i <= 1'b0;
		repeat (8) @(posedge clk);
		chk("pin irq masked", 0, irq);
		wr(5'h0c, 3);
		repeat (4) @(posedge clk);
		chk("pin irq", 1, irq);
		rd(5'h08);
		chk("pin status", 2, d);
		give_verdict;
	end
endmodule // csi_serial_bench
